// [common/bridge_cfg_pkg.sv]
// constants for the bridge configuration and control registers
package bridge_cfg_pkg;
  localparam int          NUM_PORTS        = 6;
  localparam int          UPSTREAM_PORT    = 0;
  localparam int          PORT_IDX_W       = 3;
  localparam logic [7:0]  CAP_PTR_OFFSET   = 8'h34;
  localparam logic [7:0]  INT_BRIDGE_OFFSET = 8'h3C;
  localparam logic [7:0]  CAP_PTR_VALUE    = 8'h40;
  localparam logic [7:0]  INT_LINE_RESET   = 8'h00;
  localparam logic [7:0]  INT_PIN_RESET    = 8'h00;
  localparam int          INT_LINE_LSB     = 0;
  localparam int          INT_PIN_LSB      = 8;
  localparam int          BC_PARITY_BIT    = 16;
  localparam int          BC_SERR_FWD_BIT  = 17;
  localparam int          BC_LEGACY_IO_BIT = 18;
  localparam int          BC_VGA_EN_BIT    = 19;
  localparam int          BC_VGA16_BIT     = 20;
  localparam int          BC_SEC_RST_BIT   = 22;
  localparam int          BC_RSVD_LSB      = 28;
  localparam logic [3:0]  BC_RSVD_RESET    = 4'h0;
  localparam logic [31:0] VGA_MEM_LO       = 32'h000A_0000;
  localparam logic [31:0] VGA_MEM_HI       = 32'h000B_FFFF;
  localparam logic [9:0]  VGA_IO_A_LO      = 10'h3B0;
  localparam logic [9:0]  VGA_IO_A_HI      = 10'h3BB;
  localparam logic [9:0]  VGA_IO_B_LO      = 10'h3C0;
  localparam logic [9:0]  VGA_IO_B_HI      = 10'h3DF;
  localparam logic [9:0]  LEGACY_IO_LO     = 10'h100;
  localparam logic [31:0] IO_64K_LIMIT     = 32'h0001_0000;
endpackage

// [core/bridge_config_control_regs.sv]
// per-port bridge configuration registers and forwarding decode
// Contract
// - capability pointer reads fixed 40h, pointing at power management
// - interrupt pin field bits 15:8 resets 00h, downstream load overrides
// - bit 16 clear ignores secondary poisoned TLPs, set reports them
// - bit 17 set forwards secondary error messages upstream
// - bit 18 set sends legacy I/O top 768 bytes upstream
// - bit 19 set forwards VGA memory and I/O ranges
// - VGA memory range is 000A0000h to 000BFFFFh inclusive
// - VGA I/O is low ten bits 3B0-3BB or 3C0-3DF, first 64KB
// - bit 20 selects 10-bit or 16-bit VGA I/O compare
// - bit 22 set asserts hot reset toward attached device
// - upstream secondary reset asserts every downstream port reset
// - bits 21 and 23 to 27 hardwired zero
`timescale 1ns/10ps
module bridge_config_control_regs
  import bridge_cfg_pkg::*;
(
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  cfg_wr_i,
  input  wire logic                  cfg_rd_i,
  input  wire logic [PORT_IDX_W-1:0] cfg_port_i,
  input  wire logic [7:0]            cfg_offset_i,
  input  wire logic [3:0]            cfg_byte_en_i,
  input  wire logic [31:0]           cfg_wdata_i,
  output logic      [31:0]           cfg_rdata_o,
  output logic                       cfg_rvalid_o,
  input  wire logic [7:0]            int_pin_default_i,
  input  wire logic [PORT_IDX_W-1:0] chk_port_i,
  input  wire logic [31:0]           chk_addr_i,
  input  wire logic                  chk_is_io_i,
  input  wire logic                  chk_poisoned_i,
  input  wire logic                  chk_err_msg_i,
  output logic                       fwd_vga_o,
  output logic                       fwd_legacy_up_o,
  output logic                       poison_report_o,
  output logic                       err_forward_o,
  output logic      [NUM_PORTS-1:0]  port_rst_n_o
);
  logic [31:0] rdata_w [NUM_PORTS];
  logic [5:0]  ctrl_w  [NUM_PORTS];
  logic [31:0] rdata_q;
  logic        rvalid_q;
  logic [NUM_PORTS-1:0] port_rst_n_q;

  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g++) begin : g_port
      logic wr_w;
      logic [7:0] pin_def_w;
      assign wr_w = cfg_wr_i && (cfg_port_i == PORT_IDX_W'(g));
      // upstream keeps the reset pin value, downstream may be loaded
      assign pin_def_w = (g == UPSTREAM_PORT) ? INT_PIN_RESET
                                              : int_pin_default_i;
      bridge_port_regs u_regs (
        .ref_clk_i         (ref_clk_i),
        .rst_n_i           (rst_n_i),
        .wr_i              (wr_w),
        .offset_i          (cfg_offset_i),
        .byte_en_i         (cfg_byte_en_i),
        .wdata_i           (cfg_wdata_i),
        .int_pin_default_i (pin_def_w),
        .rdata_o           (rdata_w[g]),
        .ctrl_o            (ctrl_w[g])
      );
    end
  endgenerate

  // selected port's controls for the forwarding checks
  logic [5:0] sel_ctrl_w;
  logic       port_ok_w;
  assign port_ok_w  = chk_port_i < PORT_IDX_W'(NUM_PORTS);
  assign sel_ctrl_w = port_ok_w ? ctrl_w[chk_port_i] : 6'h00;

  logic vga_mem_w;
  logic vga_io_lo_w;
  logic vga_io_w;
  logic io_64k_w;
  logic legacy_w;
  assign vga_mem_w = !chk_is_io_i && (chk_addr_i >= VGA_MEM_LO)
                     && (chk_addr_i <= VGA_MEM_HI);
  assign vga_io_lo_w = ((chk_addr_i[9:0] >= VGA_IO_A_LO)
                       && (chk_addr_i[9:0] <= VGA_IO_A_HI))
                    || ((chk_addr_i[9:0] >= VGA_IO_B_LO)
                       && (chk_addr_i[9:0] <= VGA_IO_B_HI));
  assign io_64k_w = chk_addr_i < IO_64K_LIMIT;
  // 10-bit decode aliases across all of the first 64KB
  assign vga_io_w = chk_is_io_i && io_64k_w && vga_io_lo_w
                    && (!sel_ctrl_w[4]
                        || (chk_addr_i[15:10] == 6'h00));
  assign legacy_w = chk_is_io_i && io_64k_w
                    && (chk_addr_i[9:0] >= LEGACY_IO_LO);

  assign fwd_vga_o       = sel_ctrl_w[3] && (vga_mem_w || vga_io_w);
  assign fwd_legacy_up_o = sel_ctrl_w[2] && legacy_w;
  assign poison_report_o = sel_ctrl_w[0] && chk_poisoned_i;
  assign err_forward_o   = sel_ctrl_w[1] && chk_err_msg_i;

  // port resets come from flops so they are glitch free at the pins
  logic [NUM_PORTS-1:0] rst_d;
  generate
    for (g = 0; g < NUM_PORTS; g++) begin : g_rst
      if (g == UPSTREAM_PORT) begin : g_up
        assign rst_d[g] = 1'b1;
      end else begin : g_dn
        assign rst_d[g] = !(ctrl_w[g][5]
                            || ctrl_w[UPSTREAM_PORT][5]);
      end
    end
  endgenerate

  logic [31:0] rd_sel_w;
  assign rd_sel_w = (cfg_port_i < PORT_IDX_W'(NUM_PORTS))
                    ? rdata_w[cfg_port_i] : 32'h0000_0000;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rdata_q      <= 32'h0000_0000;
      rvalid_q     <= 1'b0;
      port_rst_n_q <= {NUM_PORTS{1'b1}};
    end else begin
      rvalid_q     <= cfg_rd_i;
      rdata_q      <= cfg_rd_i ? rd_sel_w : rdata_q;
      port_rst_n_q <= rst_d;
    end
  end

  assign cfg_rdata_o  = rdata_q;
  assign cfg_rvalid_o = rvalid_q;
  assign port_rst_n_o = port_rst_n_q;
endmodule

// [core/bridge_port_regs.sv]
// one port's copy of the bridge configuration registers
`timescale 1ns/10ps
module bridge_port_regs
  import bridge_cfg_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        wr_i,
  input  wire logic [7:0]  offset_i,
  input  wire logic [3:0]  byte_en_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [7:0]  int_pin_default_i,
  output logic      [31:0] rdata_o,
  output logic      [5:0]  ctrl_o
);
  logic [7:0] int_line_q;
  logic [7:0] int_pin_q;
  logic [5:0] ctrl_q;
  logic [3:0] rsvd_q;
  logic       hit_w;
  logic       pin_load_q;

  assign hit_w = wr_i && (offset_i == INT_BRIDGE_OFFSET);

  // pin default may be replaced by sideband load, caught after reset
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      int_line_q <= INT_LINE_RESET;
      int_pin_q  <= INT_PIN_RESET;
      ctrl_q     <= 6'h00;
      rsvd_q     <= BC_RSVD_RESET;
      pin_load_q <= 1'b1;
    end else begin
      pin_load_q <= 1'b0;
      if (pin_load_q)
        int_pin_q <= int_pin_default_i;
      if (hit_w && byte_en_i[0])
        int_line_q <= wdata_i[7:0];
      if (hit_w && byte_en_i[2])
        ctrl_q[4:0] <= wdata_i[20:16];
      if (hit_w && byte_en_i[2])
        ctrl_q[5] <= wdata_i[BC_SEC_RST_BIT];
    end
  end

  // pin, hardwired and reserved bits ignore writes; reserved keep value
  assign rdata_o = (offset_i == CAP_PTR_OFFSET) ? {24'h0, CAP_PTR_VALUE}
    : (offset_i == INT_BRIDGE_OFFSET)
      ? {rsvd_q, 5'h00, ctrl_q[5], 1'b0, ctrl_q[4:0],
         int_pin_q, int_line_q}
      : 32'h0000_0000;
  assign ctrl_o = ctrl_q;
endmodule

// [verif/bridge_regs_checker.sv]
// assertions on the bridge register block ports
`timescale 1ns/10ps
module bridge_regs_checker (
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic        cfg_rd_i,
  input wire logic [2:0]  cfg_port_i,
  input wire logic [7:0]  cfg_offset_i,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic        cfg_rvalid_o,
  input wire logic [31:0] chk_addr_i,
  input wire logic        chk_is_io_i,
  input wire logic        chk_poisoned_i,
  input wire logic        fwd_vga_o,
  input wire logic        fwd_legacy_up_o,
  input wire logic        poison_report_o,
  input wire logic [5:0]  port_rst_n_o
);
  default clocking dc @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence rd_at(logic [7:0] off);
    cfg_rd_i && cfg_offset_i == off && cfg_port_i < 3'h6;
  endsequence
  chk_rvalid_pulse: assert property
    (cfg_rvalid_o == $past(cfg_rd_i)) else $error("late read answer");
  chk_cap_pointer: assert property
    (rd_at(8'h34) |=> cfg_rdata_o == 32'h40) else $error("bad pointer");
  chk_fixed_bits: assert property
    (rd_at(8'h3C) |=> cfg_rdata_o[31:23] == 9'h0 && !cfg_rdata_o[21])
    else $error("fixed control bits not zero");
  chk_vga_mem: assert property
    (fwd_vga_o && !chk_is_io_i
     |-> chk_addr_i inside {[32'hA0000:32'hBFFFF]})
    else $error("vga memory range wrong");
  chk_vga_io: assert property
    (fwd_vga_o && chk_is_io_i |-> chk_addr_i < 32'h10000 && chk_addr_i[9:0]
    inside {[10'h3B0:10'h3BB], [10'h3C0:10'h3DF]}) else $error("vga io wrong");
  chk_legacy_up: assert property
    (fwd_legacy_up_o |-> chk_is_io_i && chk_addr_i < 32'h10000)
    else $error("legacy forward outside low io");
  chk_poison_gate: assert property
    (poison_report_o |-> chk_poisoned_i) else $error("poison without cause");
  chk_up_rst_high: assert property
    (port_rst_n_o[0]) else $error("upstream port reset driven");
endmodule
bind bridge_config_control_regs bridge_regs_checker i_bridge_regs_checker (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cfg_rd_i(cfg_rd_i),
  .cfg_port_i(cfg_port_i), .cfg_offset_i(cfg_offset_i),
  .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o),
  .chk_addr_i(chk_addr_i), .chk_is_io_i(chk_is_io_i),
  .chk_poisoned_i(chk_poisoned_i), .fwd_vga_o(fwd_vga_o),
  .fwd_legacy_up_o(fwd_legacy_up_o), .poison_report_o(poison_report_o),
  .port_rst_n_o(port_rst_n_o)
);

// [verif/root_cfg_model.sv]
// root complex model issuing configuration requests
`timescale 1ns/10ps
module root_cfg_model (
  input  wire logic        ref_clk_i,
  output logic             wr_o,
  output logic             rd_o,
  output logic [2:0]       port_o,
  output logic [7:0]       offset_o,
  output logic [3:0]       be_o,
  output logic [31:0]      wdata_o
);
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    port_o = 3'h0;
    offset_o = 8'h00;
    be_o = 4'h0;
    wdata_o = 32'h0;
  end
  task automatic access(input logic wr, input logic [2:0] p,
                        input logic [7:0] off, input logic [3:0] be,
                        input logic [31:0] d);
    // random idle gap so requests come both prompt and slow
    repeat ($urandom_range(0, 2)) @(negedge ref_clk_i);
    @(negedge ref_clk_i);
    {wr_o, rd_o, port_o, offset_o, be_o, wdata_o} = {wr, !wr, p, off, be, d};
    @(negedge ref_clk_i);
    {wr_o, rd_o} = 2'b00;
    // released data must not keep showing the old value
    wdata_o = ~d;
  endtask
endmodule

// [verif/tb.sv]
// self-checking bench for the bridge register block
`timescale 1ns/10ps
module tb;
  import bridge_cfg_pkg::*;
  logic ref_clk_i, rst_n_i, cfg_wr_i, cfg_rd_i, cfg_rvalid_o, chk_is_io_i;
  logic chk_poisoned_i, chk_err_msg_i, fwd_vga_o, fwd_legacy_up_o;
  logic poison_report_o, err_forward_o;
  logic [2:0]  cfg_port_i, chk_port_i;
  logic [7:0]  cfg_offset_i, int_pin_default_i, line_e [6], bc_e [6];
  logic [3:0]  cfg_byte_en_i, be;
  logic [31:0] cfg_wdata_i, cfg_rdata_o, chk_addr_i, a;
  logic [5:0]  port_rst_n_o, rst_e;
  logic [31:0] exp_q [$];
  int          n_mismatch, compares, p;
  bridge_config_control_regs i_bridge_config_control_regs (.*);
  root_cfg_model i_root_cfg_model (.ref_clk_i(ref_clk_i), .wr_o(cfg_wr_i),
    .rd_o(cfg_rd_i), .port_o(cfg_port_i), .offset_o(cfg_offset_i),
    .be_o(cfg_byte_en_i), .wdata_o(cfg_wdata_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  task automatic note(input logic ok);
    compares++;
    if (!ok) begin
      n_mismatch++;
      $display("wrong value at %0t: output differs", $time);
    end
  endtask
  task automatic cmp_rdata(input logic [31:0] g, input logic [31:0] e);
    note(g === e);
  endtask
  task automatic cmp_ctrl(input logic [9:0] g, input logic [9:0] e);
    note(g === e);
  endtask
  task automatic rd(input logic [2:0] pt, input logic [7:0] off,
                    input logic [31:0] e);
    exp_q.push_back(e);
    i_root_cfg_model.access(1'b0, pt, off, 4'h0, 32'h0);
  endtask
  function automatic logic [3:0] fwd_ref(input logic [7:0] b,
      input logic [31:0] ad, input logic io, input logic ps, input logic er);
    logic vio;
    vio = ad < 32'h10000 && (!b[4] || ad[15:10] == 6'h0) &&
          (ad[9:0] inside {[10'h3B0:10'h3BB], [10'h3C0:10'h3DF]});
    return {b[3] && (io ? vio : ad inside {[32'hA0000:32'hBFFFF]}),
            b[2] && io && ad < 32'h10000 && ad[9:0] >= 10'h100,
            b[0] && ps, b[1] && er};
  endfunction
  always @(negedge ref_clk_i) begin
    if (cfg_rvalid_o === 1'b1) begin
      if (exp_q.size() == 0) note(1'b0);
      else cmp_rdata(cfg_rdata_o, exp_q.pop_front());
    end
  end
  task automatic finish_test();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h1E181E05));
    {rst_n_i, chk_port_i, chk_addr_i, chk_is_io_i} = '0;
    {chk_poisoned_i, chk_err_msg_i} = 2'b00;
    int_pin_default_i = 8'h01 + 8'($urandom_range(0, 200));
    repeat (16) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    @(negedge ref_clk_i);
    for (p = 0; p < 6; p++) begin
      {line_e[p], bc_e[p]} = 16'h0;
      rd(3'(p), 8'h34, 32'h40);
      rd(3'(p), 8'h3C,
         {16'h0, p == 0 ? 8'h0 : int_pin_default_i, 8'h0});
    end
    for (int n = 0; n < 600; n++) begin
      {a, be, p} = {$urandom, 4'($urandom), $urandom_range(0, 5)};
      i_root_cfg_model.access(1'b1, 3'(p), n[0] ? 8'h3C : 8'h34,
                              be, a);
      if (n[0] && be[0]) line_e[p] = a[7:0];
      if (n[0] && be[2]) bc_e[p] = a[23:16] & 8'h5F;
      {chk_port_i, chk_is_io_i} = {3'(p), 1'($urandom)};
      {chk_poisoned_i, chk_err_msg_i} = 2'($urandom);
      chk_addr_i = $urandom & (chk_is_io_i ? 32'h0001_0FFF : 32'h000F_FFFF);
      chk_addr_i = chk_addr_i | (n[1] && chk_is_io_i ? 32'h380 : 32'h0);
      for (int i = 0; i < 6; i++)
        rst_e[i] = i == 0 || !(bc_e[i][6] || bc_e[0][6]);
      @(negedge ref_clk_i);
      cmp_ctrl({fwd_vga_o, fwd_legacy_up_o, poison_report_o, err_forward_o,
        port_rst_n_o}, {fwd_ref(bc_e[p], chk_addr_i, chk_is_io_i,
        chk_poisoned_i, chk_err_msg_i),
        rst_e});
    end
    for (p = 0; p < 6; p++) rd(3'(p), 8'h3C, {8'h0, bc_e[p],
      p == 0 ? 8'h0 : int_pin_default_i, line_e[p]});
    rd(3'h6, 8'h3C, 32'h0);
    rd(3'h2, 8'h38, 32'h0);
    for (int k = 0; k < 10 && exp_q.size() != 0; k++) @(negedge ref_clk_i);
    if (exp_q.size() != 0) note(1'b0);
    finish_test();
  end
endmodule
